/* rtl/sysconf_bank.sv */
// system configuration bank: memory remap, fast-plus drive, line source select, break locks
`timescale 1ns/1ps
`include "sysconf_cfg.svh"

module sysconf_bank
  import sysconf_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        SRST_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // pins and system events
  input  wire logic [1:0]  BOOT_PINS_IN,
  input  wire port_pins_t  PORT_PINS_IN,
  input  wire logic        CORE_LOCKUP_IN,
  input  wire logic        PARITY_ERR_IN,
  input  wire logic        VMON_IRQ_IN,
  input  wire logic        WWDG_IRQ_IN,
  // configuration outputs
  output logic      [1:0]  MEM_MAP_SEL_OUT,
  output ir_src_e          IR_ENV_SEL_OUT,
  output fast_plus_s       FAST_PLUS_OUT,
  output logic      [15:0] EXT_LINE_OUT,
  output logic             TIMER_BREAK_OUT,
  output logic             VMON_CTRL_RO_OUT,
  output logic             IRQ_OUT
);

  state_s st_reg;
  state_s st_next;

  // one pin of the selected port, or low for a reserved code
  function automatic logic pick_line(input logic [3:0] code, input port_pins_t pins,
                                     input int unsigned idx);
    logic hit;
    hit = 1'b0;
    if (code[2:0] <= `LINE_CODE_MAX) begin
      hit = pins[code[2:0]][idx];
    end
    return hit;
  endfunction : pick_line

  logic        bus_setup;
  logic        bus_done;
  logic        wr_done;
  logic        mapped;
  logic [31:0] rd_word;
  logic [2:0]  irq_ev;

  assign bus_setup = PSEL_IN & PENABLE_IN & ~st_reg.pready;
  assign bus_done  = PSEL_IN & PENABLE_IN & st_reg.pready;
  assign wr_done   = bus_done & PWRITE_IN & ~st_reg.pslverr;

  // read mux; reserved bits are masked to zero
  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (PADDR_IN)
      `OFS_CFG1:      rd_word = st_reg.cfg1 & `CFG1_WR_MASK;
      `OFS_LINE_SRC0: rd_word = {16'h0000, st_reg.line_src[0]};
      `OFS_LINE_SRC1: rd_word = {16'h0000, st_reg.line_src[1]};
      `OFS_LINE_SRC2: rd_word = {16'h0000, st_reg.line_src[2]};
      `OFS_LINE_SRC3: rd_word = {16'h0000, st_reg.line_src[3]};
      `OFS_CFG2: begin
        rd_word[`CFG2_LOCKUP_BIT +: 3] = st_reg.cfg2_ctl;
        rd_word[`CFG2_FLAG_BIT]        = st_reg.parity_flag;
      end
      `OFS_IRQ_STS:   rd_word = {29'h0000_0000, st_reg.irq_sts};
      `OFS_IRQ_MASK:  rd_word = {29'h0000_0000, st_reg.irq_mask};
      `OFS_SRC_STS0:  rd_word = {31'h0000_0000, st_reg.wwdg_pend};
      default:        mapped = 1'b0;
    endcase
  end

  assign irq_ev[`IRQ_EV_PARITY] = PARITY_ERR_IN;
  assign irq_ev[`IRQ_EV_LOCKUP] = CORE_LOCKUP_IN;
  assign irq_ev[`IRQ_EV_VMON]   = VMON_IRQ_IN;

  always_comb begin
    st_next = st_reg;
    // synchronisers keep shifting through reset so the boot level is settled
    st_next.pin_sync1  = PORT_PINS_IN;
    st_next.pin_sync2  = st_reg.pin_sync1;
    st_next.boot_sync1 = BOOT_PINS_IN;
    st_next.boot_sync2 = st_reg.boot_sync1;

    // apb: setup, one wait cycle, then ready with registered data
    st_next.pready  = bus_setup;
    st_next.pslverr = bus_setup & ~mapped;
    st_next.prdata  = (bus_setup & ~PWRITE_IN) ? rd_word : 32'h0000_0000;

    if (wr_done) begin
      unique case (PADDR_IN)
        `OFS_CFG1: begin
          st_next.cfg1 = PWDATA_IN & `CFG1_WR_MASK;
        end
        `OFS_LINE_SRC0: st_next.line_src[0] = PWDATA_IN[15:0];
        `OFS_LINE_SRC1: st_next.line_src[1] = PWDATA_IN[15:0];
        `OFS_LINE_SRC2: st_next.line_src[2] = PWDATA_IN[15:0];
        `OFS_LINE_SRC3: st_next.line_src[3] = PWDATA_IN[15:0];
        `OFS_CFG2: begin
          // lockup and parity lock bits only set, reset is the sole way back; the vmon bit takes the written value
          st_next.cfg2_ctl[`CFG2_LOCKUP_BIT] = st_reg.cfg2_ctl[`CFG2_LOCKUP_BIT] |
                                               PWDATA_IN[`CFG2_LOCKUP_BIT];
          st_next.cfg2_ctl[`CFG2_PARITY_BIT] = st_reg.cfg2_ctl[`CFG2_PARITY_BIT] |
                                               PWDATA_IN[`CFG2_PARITY_BIT];
          st_next.cfg2_ctl[`CFG2_VMON_BIT]   = PWDATA_IN[`CFG2_VMON_BIT];
          if (PWDATA_IN[`CFG2_FLAG_BIT]) begin
            st_next.parity_flag = 1'b0;
          end
        end
        `OFS_IRQ_STS:  st_next.irq_sts  = st_reg.irq_sts & ~PWDATA_IN[2:0];
        `OFS_IRQ_MASK: st_next.irq_mask = PWDATA_IN[2:0];
        default: ;
      endcase
    end

    // a new event wins over a clear in the same cycle
    if (PARITY_ERR_IN) begin
      st_next.parity_flag = 1'b1;
    end
    st_next.irq_sts = st_next.irq_sts | irq_ev;

    st_next.wwdg_pend = WWDG_IRQ_IN;

    for (int unsigned i = 0; i < 16; i++) begin
      st_next.ext_line[i] = pick_line(st_reg.line_src[i / 4][(i % 4) * 4 +: 4],
                                      st_reg.pin_sync2, i);
    end

    st_next.brk = (st_reg.cfg2_ctl[`CFG2_LOCKUP_BIT] & CORE_LOCKUP_IN) |
                  (st_reg.cfg2_ctl[`CFG2_PARITY_BIT] & PARITY_ERR_IN) |
                  (st_reg.cfg2_ctl[`CFG2_VMON_BIT] & VMON_IRQ_IN);
    st_next.vmon_ro = st_next.cfg2_ctl[`CFG2_VMON_BIT];
    st_next.irq     = |(st_next.irq_sts & st_next.irq_mask);

    if (SRST_IN) begin
      st_next.cfg1        = `CFG1_RST_NOMAP;
      // mapping caught from the settled boot level while reset is held
      st_next.cfg1[`CFG1_MEMORY_MAP_SELECT_LSB +: 2] = st_reg.boot_sync2;
      st_next.line_src    = {4{`LINE_SRC_RST}};
      st_next.cfg2_ctl    = 3'(`CFG2_RST);
      st_next.parity_flag = 1'b0;
      st_next.irq_sts     = `IRQ_RST;
      st_next.irq_mask    = `IRQ_RST;
      st_next.wwdg_pend   = 1'b0;
      st_next.ext_line    = 16'h0000;
      st_next.brk         = 1'b0;
      st_next.vmon_ro     = 1'b0;
      st_next.irq         = 1'b0;
      st_next.prdata      = 32'h0000_0000;
      st_next.pready      = 1'b0;
      st_next.pslverr     = 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    st_reg <= st_next;
  end

  // map select: low bit 0 main flash, 01 system flash, 11 sram
  assign MEM_MAP_SEL_OUT  = st_reg.cfg1[`CFG1_MEMORY_MAP_SELECT_LSB +: 2];
  assign IR_ENV_SEL_OUT   = ir_src_e'(st_reg.cfg1[`CFG1_IR_ENVELOPE_SOURCE_SELECT_LSB +: 2]);
  // per-pin bits set fast-plus on one pin each; controller bits set fast-plus on all pins of that controller
  assign FAST_PLUS_OUT    = fast_plus_s'(st_reg.cfg1[`CFG1_FMP_B6 +: 8]);
  assign EXT_LINE_OUT     = st_reg.ext_line;
  assign TIMER_BREAK_OUT  = st_reg.brk;
  assign VMON_CTRL_RO_OUT = st_reg.vmon_ro;
  assign IRQ_OUT          = st_reg.irq;
  assign PRDATA_OUT       = st_reg.prdata;
  assign PREADY_OUT       = st_reg.pready;
  assign PSLVERR_OUT      = st_reg.pslverr;

endmodule : sysconf_bank

/* rtl/sysconf_cfg.svh */
// offsets, field positions, reset values and bus constants of the system configuration bank
`ifndef SYSCONF_CFG_SVH
`define SYSCONF_CFG_SVH

`define OFS_CFG1        12'h000
`define OFS_LINE_SRC0   12'h008
`define OFS_LINE_SRC1   12'h00c
`define OFS_LINE_SRC2   12'h010
`define OFS_LINE_SRC3   12'h014
`define OFS_CFG2        12'h018
`define OFS_IRQ_STS     12'h020
`define OFS_IRQ_MASK    12'h024
`define OFS_SRC_STS0    12'h080

`define CFG1_WR_MASK    32'h00ff_00c3
`define CFG1_MEMORY_MAP_SELECT_LSB  0
`define CFG1_IR_ENVELOPE_SOURCE_SELECT_LSB  6
`define CFG1_FMP_B6     16
`define CFG1_FMP_B7     17
`define CFG1_FMP_B8     18
`define CFG1_FMP_B9     19
`define CFG1_FMP_CTL1   20
`define CFG1_FMP_CTL2   21
`define CFG1_FMP_A9     22
`define CFG1_FMP_A10    23
`define CFG1_RST_NOMAP  32'h0000_0000

`define CFG2_LOCKUP_BIT 0
`define CFG2_PARITY_BIT 1
`define CFG2_VMON_BIT   2
`define CFG2_FLAG_BIT   8
`define CFG2_RST        32'h0000_0000

`define LINE_SRC_RST    16'h0000
`define LINE_CODE_MAX   3'h5

`define IRQ_EV_PARITY   0
`define IRQ_EV_LOCKUP   1
`define IRQ_EV_VMON     2
`define IRQ_RST         3'h0

`endif

/* rtl/sysconf_pkg.sv */
// types of the system configuration bank
package sysconf_pkg;

  typedef enum logic [1:0] {
    IR_SRC_TIMER_SIXTEEN    = 2'h0,
    IR_SRC_SERIAL_PORT_ONE  = 2'h1,
    IR_SRC_SERIAL_PORT_FOUR = 2'h2,
    IR_SRC_RESERVED         = 2'h3
  } ir_src_e;

  // fast-plus drive controls going to the pad ring
  typedef struct packed {
    logic pin_a10_fast_plus_drive;
    logic pin_a9_fast_plus_drive;
    logic serial_ctrl_two_fast_plus_all_pins;
    logic serial_ctrl_one_fast_plus_all_pins;
    logic pin_b9_fast_plus_drive;
    logic pin_b8_fast_plus_drive;
    logic pin_b7_fast_plus_drive;
    logic pin_b6_fast_plus_drive;
  } fast_plus_s;

  typedef logic [5:0][15:0] port_pins_t;

  typedef struct packed {
    port_pins_t        pin_sync1;
    port_pins_t        pin_sync2;
    logic [1:0]        boot_sync1;
    logic [1:0]        boot_sync2;
    logic [31:0]       cfg1;
    logic [3:0][15:0]  line_src;
    logic [2:0]        cfg2_ctl;
    logic              parity_flag;
    logic [2:0]        irq_sts;
    logic [2:0]        irq_mask;
    logic              wwdg_pend;
    logic [15:0]       ext_line;
    logic              brk;
    logic              vmon_ro;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } state_s;

endpackage : sysconf_pkg

/* verif/sysconf_bank_properties.sv */
// concurrent checks on the ports of the configuration bank
`timescale 1ns/1ps
module sysconf_bank_properties
  import sysconf_pkg::*;
(
  // clock, reset and bus
  input wire logic        MCLK_IN, SRST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT, PSLVERR_OUT,
  // pins, events and configuration outputs
  input wire logic [1:0]  BOOT_PINS_IN, MEM_MAP_SEL_OUT,
  input wire logic        CORE_LOCKUP_IN, PARITY_ERR_IN, VMON_IRQ_IN,
  input wire fast_plus_s  FAST_PLUS_OUT,
  input wire logic [15:0] EXT_LINE_OUT,
  input wire logic        TIMER_BREAK_OUT, VMON_CTRL_RO_OUT, IRQ_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  property p_one_wait;
    disable iff (SRST_IN) PSEL_IN && $rose(PENABLE_IN) |=> PREADY_OUT;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready late");
  property p_ready_pulse;
    disable iff (SRST_IN) PREADY_OUT |=> !PREADY_OUT;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_err_zero;
    disable iff (SRST_IN) PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error data");
  property p_no_break;
    disable iff (SRST_IN) !CORE_LOCKUP_IN && !PARITY_ERR_IN && !VMON_IRQ_IN |=> !TIMER_BREAK_OUT;
  endproperty
  a_no_break: assert property (p_no_break) else $error("break without cause");
  // boot pins pass a two-flop synchroniser, so four stable reset edges are asked for
  property p_boot_map;
    (SRST_IN && $stable(BOOT_PINS_IN)) [*4] |=> MEM_MAP_SEL_OUT == $past(BOOT_PINS_IN);
  endproperty
  a_boot_map: assert property (p_boot_map) else $error("boot map");
  property p_reset_out;
    SRST_IN |=> !TIMER_BREAK_OUT && !IRQ_OUT && !VMON_CTRL_RO_OUT && !PREADY_OUT
      && EXT_LINE_OUT == 16'h0000 && FAST_PLUS_OUT == 8'h00;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset outputs");
  property p_ro_write;
    disable iff (SRST_IN)
      $changed(VMON_CTRL_RO_OUT) |-> $past(PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h018);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("monitor lock moved");
  property p_fp_write;
    disable iff (SRST_IN)
      $changed(FAST_PLUS_OUT) |-> $past(PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h000);
  endproperty
  a_fp_write: assert property (p_fp_write) else $error("fast plus moved");
  c_err: cover property (PSLVERR_OUT);
  c_brk: cover property (TIMER_BREAK_OUT);
  c_irq: cover property (IRQ_OUT);
endmodule : sysconf_bank_properties

/* verif/tb_sysconf_bank.sv */
// self-checking bench of the system configuration bank
`timescale 1ns/1ps
`include "sysconf_cfg.svh"
module tb_sysconf_bank
  import sysconf_pkg::*;
;
  logic        clk, rst, psel, pen, pwr, lock, perr, vmon, wwdg, pready, pslverr, brk, vro, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [31:0] cd [4];
  logic [1:0]  boot, memory_map_select;
  logic [15:0] eline;
  logic [32:0] exp_q [$];
  port_pins_t  pins;
  ir_src_e     ir_envelope_source_select;
  fast_plus_s  fplus;
  int          n_fail, samples_checked, seed;
  sysconf_bank sysconf_bank_inst (
    .MCLK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .BOOT_PINS_IN(boot), .PORT_PINS_IN(pins), .CORE_LOCKUP_IN(lock),
    .PARITY_ERR_IN(perr), .VMON_IRQ_IN(vmon), .WWDG_IRQ_IN(wwdg), .MEM_MAP_SEL_OUT(memory_map_select),
    .IR_ENV_SEL_OUT(ir_envelope_source_select), .FAST_PLUS_OUT(fplus), .EXT_LINE_OUT(eline),
    .TIMER_BREAK_OUT(brk), .VMON_CTRL_RO_OUT(vro), .IRQ_OUT(irq));
  task automatic check(input string nm, input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // no release here, so a following transfer may start right at the ready edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      input logic [32:0] e);
    int n;
    exp_q.push_back(e);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    // pready is read at the rising edge itself, before that edge updates it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      end_of_test();
    end
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, 33'h0_0000_0000);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, {1'b0, e});
  endtask : rd
  task automatic settle();
    psel <= 1'b0; pen <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic pulse();
    @(posedge clk);
    perr <= 1'b1;
    @(posedge clk);
    perr <= 1'b0;
    @(negedge clk);
  endtask : pulse
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pready === 1'b1) check("apb", {pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    seed = 5; n_fail = 0; samples_checked = 0; d = 0; boot = 2'b11; pins = '0;
    rst = 1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0;
    lock = 0; perr = 0; vmon = 0; wwdg = 1;
    cd = '{32'hffff_ffff, 32'h0020_0041, 32'h0010_0080, 32'h00c0_0000};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`OFS_CFG1, 32'h0000_0003);
    rd(`OFS_CFG2, 32'h0000_0000);
    rd(`OFS_SRC_STS0, 32'h0000_0001);
    wr(`OFS_SRC_STS0, 32'h0000_0000);
    rd(`OFS_SRC_STS0, 32'h0000_0001);
    xfer(1'b0, 12'h004, 32'h0000_0000, 33'h1_0000_0000);
    wr(`OFS_CFG1, cd[0]);
    rd(`OFS_CFG1, 32'h00ff_00c3);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CFG1, cd[i]);
      settle();
      check("fast_plus", fplus, cd[i][23:16]);
      check("ir_sel", ir_envelope_source_select, cd[i][7:6]);
      check("map_sel", memory_map_select, cd[i][1:0]);
      @(posedge clk);
    end
    // codes 6 and 7 have no port behind them and must leave the line low
    for (int c = 0; c < 8; c++) begin
      pins <= {$random(seed), $random(seed), $random(seed)};
      d = 32'(c + 8 * (c % 2));
      wr(`OFS_LINE_SRC0, d);
      wr(`OFS_LINE_SRC3, d << 12);
      rd(`OFS_LINE_SRC3, d << 12);
      settle();
      check("line", {eline[15], eline[0]}, c < 6 ? {pins[c][15], pins[c][0]} : 2'b00);
      @(posedge clk);
    end
    wr(`OFS_CFG2, 32'h0000_0007);
    settle();
    check("vmon_ro", vro, 1'b1);
    @(posedge clk);
    wr(`OFS_CFG2, 32'h0000_0000);
    rd(`OFS_CFG2, 32'h0000_0003);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    settle();
    pulse();
    check("break", {brk, irq}, 2'b11);
    @(posedge clk);
    rd(`OFS_CFG2, 32'h0000_0103);
    wr(`OFS_CFG2, 32'h0000_0100);
    wr(`OFS_IRQ_STS, 32'h0000_0001);
    rd(`OFS_CFG2, 32'h0000_0003);
    wr(`OFS_IRQ_MASK, 32'h0000_0000);
    settle();
    check("irq_clr", {brk, irq}, 2'b00);
    pulse();
    check("irq_mask", irq, 1'b0);
    @(posedge clk);
    rd(`OFS_IRQ_STS, 32'h0000_0001);
    settle();
    end_of_test();
  end
endmodule : tb_sysconf_bank
bind sysconf_bank sysconf_bank_properties sysconf_bank_properties_inst (
  .MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .BOOT_PINS_IN(BOOT_PINS_IN),
  .MEM_MAP_SEL_OUT(MEM_MAP_SEL_OUT), .CORE_LOCKUP_IN(CORE_LOCKUP_IN),
  .PARITY_ERR_IN(PARITY_ERR_IN), .VMON_IRQ_IN(VMON_IRQ_IN), .FAST_PLUS_OUT(FAST_PLUS_OUT),
  .EXT_LINE_OUT(EXT_LINE_OUT), .TIMER_BREAK_OUT(TIMER_BREAK_OUT),
  .VMON_CTRL_RO_OUT(VMON_CTRL_RO_OUT), .IRQ_OUT(IRQ_OUT));
